/* rtl/relay_output_disarm_control.sv */
// Disarm control for slot groups of relay output contacts
`timescale 1ns/1ps

module relay_output_disarm_control #(
    parameter int unsigned TIMEOUT_CYCLES = disarm_pkg::TIMEOUT_CYCLES
) (
    // Clock and reset
    input  wire logic                              i_clk_sys,
    input  wire logic                              i_rst,
    // Protection drive and contact status, one bit per contact
    input  wire logic [disarm_pkg::N_OUTS-1:0]     i_drive,
    input  wire logic [disarm_pkg::N_OUTS-1:0]     i_latched,
    input  wire logic [disarm_pkg::N_OUTS-1:0]     i_hold_running,
    // Contacts that are never disarmed
    input  wire logic                              i_zone_drive,
    input  wire logic                              i_supv_drive,
    // Operator controls
    input  wire logic                              i_disarm_ctrl,
    input  wire logic [disarm_pkg::N_GROUPS-1:0]   i_disarm_cmd,
    input  wire logic [disarm_pkg::N_GROUPS-1:0]   i_disarm_perm,
    // Contact outputs
    output logic      [disarm_pkg::N_OUTS-1:0]     o_contact,
    output logic                                   o_zone_contact,
    output logic                                   o_supv_contact,
    // Status
    output logic      [disarm_pkg::N_GROUPS-1:0]   o_group_disarmed,
    output logic      [disarm_pkg::N_GROUPS-1:0]   o_group_refused
);

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Spread one bit per group over all contacts of that group
    function automatic logic [disarm_pkg::N_OUTS-1:0] expand_mask(
        input logic [disarm_pkg::N_GROUPS-1:0] grp
    );
        logic [disarm_pkg::N_OUTS-1:0] m;
        m = '0;
        for (int g = 0; g < disarm_pkg::N_GROUPS; g++) begin
            for (int c = 0; c < disarm_pkg::N_CONTACTS; c++) begin
                m[g*disarm_pkg::N_CONTACTS + c] = grp[g];
            end
        end
        return m;
    endfunction : expand_mask

    // Reduce a per-contact vector to one OR bit per group
    function automatic logic [disarm_pkg::N_GROUPS-1:0] any_in_group(
        input logic [disarm_pkg::N_OUTS-1:0] v
    );
        logic [disarm_pkg::N_GROUPS-1:0] r;
        r = '0;
        for (int g = 0; g < disarm_pkg::N_GROUPS; g++) begin
            r[g] = |v[g*disarm_pkg::N_CONTACTS +: disarm_pkg::N_CONTACTS];
        end
        return r;
    endfunction : any_in_group

    localparam logic [disarm_pkg::TIMER_W-1:0] TIMER_LAST =
        disarm_pkg::TIMER_W'(TIMEOUT_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////////////
    // Group state

    disarm_pkg::disarm_state_type state_r [disarm_pkg::N_GROUPS];
    logic [disarm_pkg::TIMER_W-1:0] timer_r [disarm_pkg::N_GROUPS];
    logic [disarm_pkg::N_GROUPS-1:0] latch_grp;
    logic [disarm_pkg::N_GROUPS-1:0] hold_grp;
    logic [disarm_pkg::N_GROUPS-1:0] request;
    logic [disarm_pkg::N_GROUPS-1:0] may_disarm;
    logic [disarm_pkg::N_GROUPS-1:0] disarmed;

    // A group is only as free as its busiest contact, so one latched or
    // holding contact keeps the whole group armed
    always_comb begin
        latch_grp  = any_in_group(i_latched);
        hold_grp   = any_in_group(i_hold_running);
        request    = i_disarm_cmd & {disarm_pkg::N_GROUPS{i_disarm_ctrl}};
        may_disarm = request & ~latch_grp & ~hold_grp;
        for (int g = 0; g < disarm_pkg::N_GROUPS; g++) begin
            disarmed[g] = (state_r[g] == disarm_pkg::DIS_PERM) ||
                          (state_r[g] == disarm_pkg::DIS_TIMED);
        end
    end

    // Per-group sequence; after expiry the command must drop before a new
    // disarm, otherwise a held command would rearm the timer forever
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            for (int g = 0; g < disarm_pkg::N_GROUPS; g++) begin
                state_r[g] <= disarm_pkg::ARMED;
            end
        end else begin
            for (int g = 0; g < disarm_pkg::N_GROUPS; g++) begin
                unique case (state_r[g])
                    disarm_pkg::ARMED: begin
                        if (may_disarm[g] && i_disarm_perm[g]) begin
                            state_r[g] <= disarm_pkg::DIS_PERM;
                        end else if (may_disarm[g]) begin
                            state_r[g] <= disarm_pkg::DIS_TIMED;
                        end
                    end
                    disarm_pkg::DIS_PERM: begin
                        if (!request[g]) begin
                            state_r[g] <= disarm_pkg::ARMED;
                        end
                    end
                    disarm_pkg::DIS_TIMED: begin
                        if (!request[g]) begin
                            state_r[g] <= disarm_pkg::ARMED;
                        end else if (timer_r[g] == TIMER_LAST) begin
                            state_r[g] <= disarm_pkg::EXPIRED;
                        end
                    end
                    disarm_pkg::EXPIRED: begin
                        if (!request[g]) begin
                            state_r[g] <= disarm_pkg::ARMED;
                        end
                    end
                endcase
            end
        end
    end

    // Timeout counters, cleared whenever a group is not timing
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            for (int g = 0; g < disarm_pkg::N_GROUPS; g++) begin
                timer_r[g] <= disarm_pkg::TIMER_ZERO;
            end
        end else begin
            for (int g = 0; g < disarm_pkg::N_GROUPS; g++) begin
                if (state_r[g] == disarm_pkg::DIS_TIMED) begin
                    timer_r[g] <= timer_r[g] + disarm_pkg::TIMER_ONE;
                end else begin
                    timer_r[g] <= disarm_pkg::TIMER_ZERO;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    // Contacts follow the protection drive unless their group is disarmed;
    // masking the drive each cycle means re-arming needs no restore step
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_contact <= disarm_pkg::OUTS_RST;
        end else begin
            o_contact <= i_drive & ~expand_mask(disarmed);
        end
    end

    // Zone interlock and supervision contact bypass disarming
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_zone_contact <= 1'b0;
            o_supv_contact <= 1'b0;
        end else begin
            o_zone_contact <= i_zone_drive;
            o_supv_contact <= i_supv_drive;
        end
    end

    // Status: disarmed groups, and requests held off by latch or hold time
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_group_disarmed <= disarm_pkg::GROUPS_RST;
            o_group_refused  <= disarm_pkg::GROUPS_RST;
        end else begin
            o_group_disarmed <= disarmed;
            o_group_refused  <= request & (latch_grp | hold_grp) & ~disarmed;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    AST_BLOCK_OUT: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        1'b1 |=> ((o_contact & $past(expand_mask(disarmed))) == '0))
        else $error("Disarmed group contact switched");

    AST_FOLLOW_DRIVE: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        (disarmed == '0) |=> (o_contact == $past(i_drive)))
        else $error("Armed contacts do not follow drive");

    // Status and contacts share one edge, so every contact of a group not
    // flagged disarmed must carry the drive of the edge before
    AST_GROUP_UNIT: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        1'b1 |=> (((o_contact ^ $past(i_drive)) & ~expand_mask(o_group_disarmed)) == '0))
        else $error("Disarm leaked across group boundary");

    AST_PASS_ZONE: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        1'b1 |=>
            (o_zone_contact == $past(i_zone_drive)) &&
            (o_supv_contact == $past(i_supv_drive)))
        else $error("Zone or supervision contact blocked");

    AST_CTRL_OFF: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        !i_disarm_ctrl |=> (disarmed == '0))
        else $error("Disarmed without enabling control");

    AST_NO_LATCH: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        1'b1 |=> ((disarmed & ~$past(disarmed) & $past(latch_grp)) == '0))
        else $error("Group with latched contact disarmed");

    AST_NO_HOLD: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        1'b1 |=> ((disarmed & ~$past(disarmed) & $past(hold_grp)) == '0))
        else $error("Group with running hold timer disarmed");

    AST_NEED_CMD: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        (request == '0) |=> (disarmed == '0) ##1 (o_group_disarmed == '0))
        else $error("Disarmed without direct command");

    AST_PERM_HOLD: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        (state_r[0] == disarm_pkg::DIS_PERM && request[0]) |=>
            (state_r[0] == disarm_pkg::DIS_PERM))
        else $error("Permanent disarm dropped while requested");

    AST_TIMER_END: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        (state_r[0] == disarm_pkg::DIS_TIMED && timer_r[0] == TIMER_LAST) |=>
            !disarmed[0] ##1 !o_group_disarmed[0])
        else $error("Timed disarm outlived its timeout");

endmodule : relay_output_disarm_control

/* rtl/disarm_pkg.sv */
// Constants and types for the relay output disarm control
// Summary of operation
// - Disarmed group contacts never switch
// - Disarm acts on whole slot groups only
// - Zone interlock and supervision contact pass
// - Timed disarm ends when timer expires
// - Permanent disarm holds until command withdrawn
// - No disarm while a contact is latched
// - No disarm while off-delay hold runs
// - Disarm needs the enabling control active
// - Disarm needs explicit direct command present
package disarm_pkg;

    // Group layout
    localparam int unsigned N_GROUPS   = 4;
    localparam int unsigned N_CONTACTS = 6;
    localparam int unsigned N_OUTS     = N_GROUPS * N_CONTACTS;

    // Timing: system clock rate and default disarm timeout
    localparam int unsigned CLK_KHZ         = 10000;
    localparam int unsigned TIMEOUT_MS      = 1000;
    localparam int unsigned TIMEOUT_CYCLES  = TIMEOUT_MS * CLK_KHZ;
    localparam int unsigned TIMER_W         = 24;
    localparam logic [TIMER_W-1:0] TIMER_ZERO = 24'h000000;
    localparam logic [TIMER_W-1:0] TIMER_ONE  = 24'h000001;

    // Reset values
    localparam logic [N_OUTS-1:0]   OUTS_RST   = 24'h000000;
    localparam logic [N_GROUPS-1:0] GROUPS_RST = 4'h0;

    // Per-group disarm state
    typedef enum logic [1:0] {
        ARMED,
        DIS_PERM,
        DIS_TIMED,
        EXPIRED
    } disarm_state_type;

endpackage : disarm_pkg

/* tb/relay_bank_model.sv */
// Behavioural bank of physical relay contacts on the far side
`timescale 1ns/1ps
module relay_bank_model (
    // Clock and contact drive from the block
    input  wire logic                          i_clk_sys,
    input  wire logic [disarm_pkg::N_OUTS-1:0] i_contact,
    // Clear and switching actions seen since the last clear
    input  wire logic                          i_clear,
    output logic      [disarm_pkg::N_OUTS-1:0] o_switched
);
    logic [disarm_pkg::N_OUTS-1:0] state_r;

    // A contact that changes position counts as one switching action
    always_ff @(posedge i_clk_sys) begin
        state_r    <= i_contact;
        o_switched <= i_clear ? disarm_pkg::OUTS_RST : o_switched | (state_r ^ i_contact);
    end
endmodule : relay_bank_model

/* tb/test_relay_output_disarm_control.sv */
// Self-checking bench for the relay output disarm control
`timescale 1ns/1ps
module test_relay_output_disarm_control;
    localparam int unsigned TMO = 8;
    logic        i_clk_sys, i_rst, zone, supv, ctrl, clr, zc, sc;
    logic [23:0] drive, latched, hold, contact, sw;
    logic [3:0]  cmd, perm, dis, refused;
    int          fail_count, n_compared, g;

    relay_output_disarm_control #(.TIMEOUT_CYCLES(TMO)) u_relay_output_disarm_control (
        .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_drive(drive), .i_latched(latched),
        .i_hold_running(hold), .i_zone_drive(zone), .i_supv_drive(supv),
        .i_disarm_ctrl(ctrl), .i_disarm_cmd(cmd), .i_disarm_perm(perm),
        .o_contact(contact), .o_zone_contact(zc), .o_supv_contact(sc),
        .o_group_disarmed(dis), .o_group_refused(refused));

    relay_bank_model u_relay_bank_model (
        .i_clk_sys(i_clk_sys), .i_contact(contact), .i_clear(clr), .o_switched(sw));

    // Free-running system clock
    initial begin
        i_clk_sys = 1'b0;
        forever #50 i_clk_sys = ~i_clk_sys;
    end

    // Drive with the bits of masked groups forced off
    function automatic logic [23:0] exp_c(input logic [23:0] d, input logic [3:0] m);
        logic [23:0] r;
        for (int i = 0; i < 24; i++)
            r[i] = d[i] & ~m[i / disarm_pkg::N_CONTACTS];
        return r;
    endfunction : exp_c

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One edge of fresh random drive; outputs checked against the drive just sampled
    task automatic tick(input logic [3:0] m, input logic cl);
        logic [23:0] dp;
        logic        zp, sp;
        @(posedge i_clk_sys);
        dp = drive;
        zp = zone;
        sp = supv;
        drive <= 24'($urandom);
        zone  <= 1'($urandom);
        supv  <= 1'($urandom);
        clr   <= cl;
        @(negedge i_clk_sys);
        check(contact, exp_c(dp, m));
        check({zc, sc}, {zp, sp});
        check(dis, m);
    endtask : tick

    task automatic req(input logic c, input logic [3:0] cm, input logic [3:0] p);
        @(posedge i_clk_sys);
        ctrl <= c;
        cmd  <= cm;
        perm <= p;
        @(negedge i_clk_sys);
    endtask : req

    task automatic flags(input logic [23:0] l, input logic [23:0] h);
        @(posedge i_clk_sys);
        latched <= l;
        hold    <= h;
        @(negedge i_clk_sys);
    endtask : flags

    task automatic final_report;
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : final_report

    // Watchdog: the whole run needs well under a thousand edges
    initial begin
        repeat (4000) @(posedge i_clk_sys);
        fail_count++;
        final_report();
    end

    initial begin
        {drive, latched, hold, zone, supv, ctrl, cmd, perm} = '0;
        {clr, i_rst, fail_count, n_compared} = '0;
        clr   = 1'b1;
        i_rst = 1'b1;
        void'($urandom(49080));
        repeat (8) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        check({contact, zc, sc, dis, refused}, 64'h0);
        @(posedge i_clk_sys);
        i_rst <= 1'b0;
        repeat (6) tick(4'h0, 1'b0);
        $display("test armed done");
        for (g = 0; g < 4; g++) begin
            // Permanent disarm holds until withdrawn; no contact of the group moves
            req(1'b1, 4'h1 << g, 4'hF);
            tick(4'h0, 1'b0);
            tick(4'h1 << g, 1'b1);
            repeat (5) tick(4'h1 << g, 1'b0);
            check(sw & exp_c(24'hFFFFFF, ~(4'h1 << g)), 64'h0);
            req(1'b1, 4'h0, 4'hF);
            tick(4'h1 << g, 1'b0);
            repeat (3) tick(4'h0, 1'b0);
            // Timed disarm drops by itself while the command is still held
            req(1'b1, 4'h1 << g, 4'h0);
            tick(4'h0, 1'b0);
            repeat (TMO) tick(4'h1 << g, 1'b0);
            repeat (3) tick(4'h0, 1'b0);
            req(1'b1, 4'h0, 4'h0);
            // One latched, then one holding contact blocks the whole group
            flags(24'h1 << (g * 6 + $urandom_range(5)), 24'h0);
            req(1'b1, 4'h1 << g, 4'hF);
            repeat (3) tick(4'h0, 1'b0);
            check(refused, 4'h1 << g);
            flags(24'h0, 24'h1 << (g * 6 + $urandom_range(5)));
            repeat (3) tick(4'h0, 1'b0);
            check(refused, 4'h1 << g);
            flags(24'h0, 24'h0);
            tick(4'h0, 1'b0);
            tick(4'h1 << g, 1'b0);
            req(1'b1, 4'h0, 4'hF);
            tick(4'h1 << g, 1'b0);
            tick(4'h0, 1'b0);
            // Command without the enabling control is ignored
            req(1'b0, 4'h1 << g, 4'hF);
            repeat (3) tick(4'h0, 1'b0);
            check(refused, 4'h0);
            req(1'b1, 4'h0, 4'hF);
            $display("test group %0d done", g);
        end
        final_report();
    end
endmodule : test_relay_output_disarm_control
